//--- common/eau_pkg.sv
package eau_pkg;

  // ==========================================================
  // encodings
  typedef enum logic [3:0] {
    EAU_DIRECT   = 4'h0,
    EAU_INDIRECT = 4'h1,
    EAU_POSTINC  = 4'h2,
    EAU_PREDEC   = 4'h3,
    EAU_DISP4    = 4'h4,
    EAU_INDEXED  = 4'h5,
    EAU_GBRDISP  = 4'h6,
    EAU_PCDISP8  = 4'h7,
    EAU_PCDISP12 = 4'h8,
    EAU_PCREG    = 4'h9,
    EAU_IMM_ZX   = 4'hA,
    EAU_IMM_SX   = 4'hB,
    EAU_IMM_TRAP = 4'hC
  } eau_mode_t;

  typedef enum logic [1:0] {
    EAU_BYTE = 2'h0,
    EAU_WORD = 2'h1,
    EAU_LONG = 2'h2
  } eau_size_t;

  // ==========================================================
  // request and result carriers
  typedef struct packed {
    logic        valid;
    eau_mode_t   mode;
    eau_size_t   size;
    logic [31:0] general_register_n;
    logic [31:0] register_zero;
    logic [31:0] global_base_register;
    logic [31:0] pc;
    logic [11:0] disp;
    logic [7:0]  imm;
  } eau_req_t;

  typedef struct packed {
    logic        valid;
    logic        is_address;
    logic        is_register;
    logic        is_immediate;
    logic [31:0] value;
    logic        write_back;
    logic [31:0] write_back_value;
  } eau_res_t;

  localparam eau_res_t EAU_RES_RESET = '0;

endpackage

//--- dv/eau_dec_model.sv
`timescale 1ns/1ps
module eau_dec_model
  import eau_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       issue,
  input  wire logic [3:0] mode,
  input  wire logic [1:0] size,
  output eau_req_t        req
);
  integer seed = 32'h8608;
  // ==========================================================
  // decoder: fresh fields every cycle, so idle fields never look stale
  always @(posedge core_clk) begin
    req.valid                <= issue && !reset;
    req.mode                 <= eau_mode_t'(mode);
    req.size                 <= eau_size_t'(size);
    req.general_register_n   <= $random(seed);
    req.register_zero        <= $random(seed);
    req.global_base_register <= $random(seed);
    req.pc                   <= $random(seed);
    req.disp                 <= 12'($random(seed));
    req.imm                  <= 8'($random(seed));
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import eau_pkg::*;
  logic       core_clk;
  logic       reset;
  logic       issue;
  logic [3:0] mode;
  logic [1:0] size;
  eau_req_t   req;
  eau_res_t   res;
  eau_res_t   expq[$];
  eau_res_t   e;
  integer     seed = 32'h8608;
  int         fails = 0;
  int         compares = 0;
  eau_dec_model eau_dec_model_inst (.core_clk(core_clk), .reset(reset), .issue(issue),
                                    .mode(mode), .size(size), .req(req));
  eau_unit eau_unit_inst (.core_clk(core_clk), .reset(reset), .req(req), .res(res));
  function automatic eau_res_t exp_of(eau_req_t q);
    eau_res_t    r;
    logic [31:0] st;
    r = '0;
    r.valid = 1'h1;
    st = (q.size == EAU_BYTE) ? 32'h1 : (q.size == EAU_WORD) ? 32'h2 : 32'h4;
    r.is_address = q.mode inside {[EAU_INDIRECT:EAU_PCREG]};
    r.is_immediate = q.mode inside {[EAU_IMM_ZX:EAU_IMM_TRAP]};
    case (q.mode)
      EAU_DIRECT: begin
        r.is_register = 1'h1;
        r.value = q.general_register_n;
      end
      EAU_INDIRECT: r.value = q.general_register_n;
      EAU_POSTINC: begin
        r.value = q.general_register_n;
        r.write_back = 1'h1;
        r.write_back_value = q.general_register_n + st;
      end
      EAU_PREDEC: begin
        r.value = q.general_register_n - st;
        r.write_back = 1'h1;
        r.write_back_value = r.value;
      end
      EAU_DISP4: r.value = q.general_register_n + {28'h0, q.disp[3:0]} * st;
      EAU_INDEXED: r.value = q.general_register_n + q.register_zero;
      EAU_GBRDISP: r.value = q.global_base_register + {24'h0, q.disp[7:0]} * st;
      EAU_PCDISP8: r.value = q.pc + {{23{q.disp[7]}}, q.disp[7:0], 1'b0};
      EAU_PCDISP12: r.value = q.pc + {{19{q.disp[11]}}, q.disp[11:0], 1'b0};
      EAU_PCREG: r.value = q.pc + q.general_register_n;
      EAU_IMM_ZX: r.value = {24'h0, q.imm};
      EAU_IMM_SX: r.value = {{24{q.imm[7]}}, q.imm};
      EAU_IMM_TRAP: r.value = {22'h0, q.imm, 2'h0};
      default: r.valid = 1'h1;
    endcase
    return r;
  endfunction
  task wrap_up;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  // ==========================================================
  // note each request the decoder hands over
  always @(posedge core_clk) begin
    #1;
    if (reset === 1'h0 && req.valid === 1'h1)
      expq.push_back(exp_of(req));
  end
  // ==========================================================
  // watch results; idle cycles must show all zero
  always @(negedge core_clk) begin
    if (reset === 1'h0) begin
      e = '0;
      if (res.valid === 1'h1 && expq.size() > 0)
        e = expq.pop_front();
      compares++;
      if (res !== e) begin
        fails++;
        $display("CHECK FAILED res expected %h seen %h", e, res);
      end
    end
  end
  initial begin
    reset = 1'h1;
    issue = 1'h0;
    mode = 4'h0;
    size = 2'h0;
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    for (int m = 0; m < 16; m++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge core_clk);
        issue <= 1'h1;
        mode <= m[3:0];
        size <= s[1:0];
      end
    end
    repeat (400) begin
      @(posedge core_clk);
      issue <= 1'($random(seed));
      mode <= 4'($random(seed));
      size <= 2'($random(seed));
    end
    @(posedge core_clk);
    issue <= 1'h0;
    for (int i = 0; i < 10 && expq.size() > 0; i++)
      @(posedge core_clk);
    if (expq.size() > 0) begin
      fails++;
      $display("CHECK FAILED pending expected 0 seen %0d", expq.size());
    end
    wrap_up();
  end
endmodule

//--- hw/eau_unit.sv
`timescale 1ns/1ps
module eau_unit
  import eau_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     reset,
  input  wire eau_req_t req,
  output eau_res_t      res
);

  // ==========================================================
  // combinational address generation
  eau_res_t    next_res;
  logic [31:0] step;
  logic [31:0] disp4_scaled;
  logic [31:0] disp8_scaled;
  logic [31:0] pc8;
  logic [31:0] pc12;

  always_comb begin
    unique case (req.size)
      EAU_BYTE: step = 32'h0000_0001;
      EAU_WORD: step = 32'h0000_0002;
      default:  step = 32'h0000_0004;
    endcase
    // zero-extended displacement, scaled by operand size
    disp4_scaled = {28'h0, req.disp[3:0]};
    disp8_scaled = {24'h0, req.disp[7:0]};
    unique case (req.size)
      EAU_BYTE: ;
      EAU_WORD: begin
        disp4_scaled = {disp4_scaled[30:0], 1'h0};
        disp8_scaled = {disp8_scaled[30:0], 1'h0};
      end
      default: begin
        disp4_scaled = {disp4_scaled[29:0], 2'h0};
        disp8_scaled = {disp8_scaled[29:0], 2'h0};
      end
    endcase
    pc8  = {{23{req.disp[7]}}, req.disp[7:0], 1'h0};
    pc12 = {{19{req.disp[11]}}, req.disp[11:0], 1'h0};

    next_res       = EAU_RES_RESET;
    next_res.valid = req.valid;
    unique case (req.mode)
      EAU_DIRECT: begin
        next_res.is_register = 1'h1;
        next_res.value       = req.general_register_n;
      end
      EAU_INDIRECT: begin
        next_res.is_address = 1'h1;
        next_res.value      = req.general_register_n;
      end
      EAU_POSTINC: begin
        next_res.is_address       = 1'h1;
        next_res.value            = req.general_register_n;
        next_res.write_back       = 1'h1;
        next_res.write_back_value = req.general_register_n + step;
      end
      EAU_PREDEC: begin
        next_res.is_address       = 1'h1;
        next_res.value            = req.general_register_n - step;
        next_res.write_back       = 1'h1;
        next_res.write_back_value = req.general_register_n - step;
      end
      EAU_DISP4: begin
        next_res.is_address = 1'h1;
        next_res.value      = req.general_register_n + disp4_scaled;
      end
      EAU_INDEXED: begin
        next_res.is_address = 1'h1;
        next_res.value      = req.general_register_n + req.register_zero;
      end
      EAU_GBRDISP: begin
        next_res.is_address = 1'h1;
        next_res.value      = req.global_base_register + disp8_scaled;
      end
      EAU_PCDISP8: begin
        next_res.is_address = 1'h1;
        next_res.value      = req.pc + pc8;
      end
      EAU_PCDISP12: begin
        next_res.is_address = 1'h1;
        next_res.value      = req.pc + pc12;
      end
      EAU_PCREG: begin
        next_res.is_address = 1'h1;
        next_res.value      = req.pc + req.general_register_n;
      end
      EAU_IMM_ZX: begin
        next_res.is_immediate = 1'h1;
        next_res.value        = {24'h0, req.imm};
      end
      EAU_IMM_SX: begin
        next_res.is_immediate = 1'h1;
        next_res.value        = {{24{req.imm[7]}}, req.imm};
      end
      EAU_IMM_TRAP: begin
        next_res.is_immediate = 1'h1;
        next_res.value        = {22'h0, req.imm, 2'h0};
      end
      default: ;
    endcase
    if (!req.valid) begin
      next_res = EAU_RES_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      res <= EAU_RES_RESET;
    end else begin
      res <= next_res;
    end
  end

  // ==========================================================
  // checks
  a_postinc_step: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_POSTINC && req.size == EAU_LONG) |=>
    (res.write_back && res.write_back_value == $past(req.general_register_n) + 32'h0000_0004))
    else $error("post-increment step wrong");
  a_predec_addr: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_PREDEC) |=> (res.value == res.write_back_value))
    else $error("pre-decrement address differs from write-back");
  a_indirect_same: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_INDIRECT) |=>
    (!res.write_back && res.value == $past(req.general_register_n)))
    else $error("indirect address wrong");
  a_direct_noaddr: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_DIRECT) |=> (res.is_register && !res.is_address))
    else $error("direct mode made an address");
  a_indexed_sum: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_INDEXED) |=>
    (res.value == $past(req.general_register_n) + $past(req.register_zero)))
    else $error("indexed sum wrong");
  a_gbr_word: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_GBRDISP && req.size == EAU_WORD) |=>
    (res.value == $past(req.global_base_register) + {23'h0, $past(req.disp[7:0]), 1'h0}))
    else $error("base displacement wrong");
  a_pcreg_sum: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_PCREG) |=>
    (res.value == $past(req.pc) + $past(req.general_register_n)))
    else $error("pc register sum wrong");
  a_trap_imm: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_IMM_TRAP) |=>
    (res.value[1:0] == 2'h0 && res.value[9:2] == $past(req.imm) && res.value[31:10] == '0))
    else $error("trap immediate wrong");
  a_sx_imm: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_IMM_SX) |=>
    (res.value[7:0] == $past(req.imm) && res.value[31:8] == {24{res.value[7]}}))
    else $error("immediate not sign-extended");
  a_postinc_byte: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_POSTINC && req.size == EAU_BYTE) |=>
    (res.value == $past(req.general_register_n) &&
     res.write_back_value == $past(req.general_register_n) + 32'h0000_0001))
    else $error("post-increment byte step wrong");
  a_postinc_word: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_POSTINC && req.size == EAU_WORD) |=>
    (res.value == $past(req.general_register_n) &&
     res.write_back_value == $past(req.general_register_n) + 32'h0000_0002))
    else $error("post-increment word step wrong");
  a_predec_byte: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_PREDEC && req.size == EAU_BYTE) |=>
    (res.write_back && res.value == $past(req.general_register_n) - 32'h0000_0001))
    else $error("pre-decrement byte address wrong");
  a_predec_word: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_PREDEC && req.size == EAU_WORD) |=>
    (res.write_back && res.value == $past(req.general_register_n) - 32'h0000_0002))
    else $error("pre-decrement word address wrong");
  a_predec_long: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_PREDEC && req.size == EAU_LONG) |=>
    (res.write_back && res.value == $past(req.general_register_n) - 32'h0000_0004))
    else $error("pre-decrement long address wrong");
  a_disp4_byte: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_DISP4 && req.size == EAU_BYTE) |=>
    (res.is_address &&
     res.value == $past(req.general_register_n) + {28'h0, $past(req.disp[3:0])}))
    else $error("short displacement byte wrong");
  a_disp4_word: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_DISP4 && req.size == EAU_WORD) |=>
    (res.is_address &&
     res.value == $past(req.general_register_n) + {27'h0, $past(req.disp[3:0]), 1'h0}))
    else $error("short displacement word wrong");
  a_disp4_long: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_DISP4 && req.size == EAU_LONG) |=>
    (res.is_address &&
     res.value == $past(req.general_register_n) + {26'h0, $past(req.disp[3:0]), 2'h0}))
    else $error("short displacement long wrong");
  a_gbr_byte: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_GBRDISP && req.size == EAU_BYTE) |=>
    (res.is_address &&
     res.value == $past(req.global_base_register) + {24'h0, $past(req.disp[7:0])}))
    else $error("base displacement byte wrong");
  a_gbr_long: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_GBRDISP && req.size == EAU_LONG) |=>
    (res.is_address &&
     res.value == $past(req.global_base_register) + {22'h0, $past(req.disp[7:0]), 2'h0}))
    else $error("base displacement long wrong");
  a_pc8_sum: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_PCDISP8) |=>
    (res.is_address &&
     res.value == $past(req.pc) + {{23{$past(req.disp[7])}}, $past(req.disp[7:0]), 1'h0}))
    else $error("short pc-relative sum wrong");
  a_pc12_sum: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_PCDISP12) |=>
    (res.is_address &&
     res.value == $past(req.pc) + {{19{$past(req.disp[11])}}, $past(req.disp[11:0]), 1'h0}))
    else $error("long pc-relative sum wrong");
  a_zx_imm: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_IMM_ZX) |=>
    (res.is_immediate && res.value == {24'h0, $past(req.imm)}))
    else $error("immediate not zero-extended");
  a_imm_kind: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode inside {EAU_IMM_ZX, EAU_IMM_SX, EAU_IMM_TRAP}) |=>
    (res.is_immediate && !res.is_address && !res.is_register && !res.write_back))
    else $error("immediate flags wrong");
  a_plain_nowb: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && !(req.mode inside {EAU_POSTINC, EAU_PREDEC})) |=> !res.write_back)
    else $error("write-back in a mode that keeps the register");
  a_direct_value: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_DIRECT) |=>
    (res.value == $past(req.general_register_n) && !res.write_back))
    else $error("direct operand wrong");
  a_indirect_kind: assert property (@(posedge core_clk) disable iff (reset)
    (req.valid && req.mode == EAU_INDIRECT) |=>
    (res.is_address && !res.is_register && !res.is_immediate))
    else $error("indirect flags wrong");

endmodule
